// file: rtl/srpi_top.sv
// Chosen here: the AXI4-Lite interface to the registers.
module srpi_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic b3_done,
  input wire logic [7:0] b3_err_mask,
  input wire srpi_pkg::srpi_byte_t spe_in,
  input wire logic spe_in_valid,
  output srpi_pkg::srpi_byte_t spe_out,
  output logic spe_out_valid,
  input wire logic serial_overhead_input,
  output logic overhead_port_clock,
  output logic overhead_port_enable_out,
  output logic overhead_port_frame_out
);

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] tx_ctrl_q, rx_ctrl_q, g1_val_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, latest_err_q;
  logic aw_got_q, w_got_q, wstrb0_q;
  logic [15:0] awaddr_q;
  logic [7:0] wdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [3:0] latest_cnt_q, frame_rei_q, ext_rei_q, ext_shift_q;
  srpi_pkg::srpi_oh_state_t oh_state_q;
  // Address decode
  wire aw_fire = awvalid && awready_q;
  wire w_fire = wvalid && wready_q;
  wire ar_fire = arvalid && arready_q;
  wire do_wr = aw_got_q && w_got_q && !bvalid_q;
  wire [15:0] wr_idx = {2'h0, awaddr_q[15:2]};
  wire [15:0] rd_idx = {2'h0, araddr[15:2]};
  wire wr_tx = wr_idx == srpi_pkg::TX_CTRL_IDX;
  wire wr_rx = wr_idx == srpi_pkg::RX_CTRL_IDX;
  wire wr_g1 = wr_idx == srpi_pkg::G1_VAL_IDX;
  wire wr_st = wr_idx == srpi_pkg::STATUS_IDX;
  wire wr_hit = wr_tx || wr_rx || wr_g1 || wr_st;
  wire rd_tx = rd_idx == srpi_pkg::TX_CTRL_IDX;
  wire rd_rx = rd_idx == srpi_pkg::RX_CTRL_IDX;
  wire rd_g1 = rd_idx == srpi_pkg::G1_VAL_IDX;
  wire rd_st = rd_idx == srpi_pkg::STATUS_IDX;
  wire rd_hit = rd_tx || rd_rx || rd_g1 || rd_st;
  wire wr_lane = do_wr && wstrb0_q;
  wire oh_busy = oh_state_q == srpi_pkg::OH_RUN;
  wire [7:0] status_val = {2'h0, oh_busy, latest_err_q, frame_rei_q};
  wire [7:0] rd_val = rd_tx ? tx_ctrl_q :
                      rd_rx ? rx_ctrl_q :
                      rd_g1 ? g1_val_q :
                      rd_st ? status_val : 8'h00;
  // Write channel handshake and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= srpi_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awready_q <= 1'b0;
        aw_got_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (w_fire) begin
        wready_q <= 1'b0;
        w_got_q <= 1'b1;
        wdata_q <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? srpi_pkg::RESP_OKAY : srpi_pkg::RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end
  // Read channel, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= srpi_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= rd_hit ? srpi_pkg::RESP_OKAY : srpi_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end
  // Control registers; upper receive nibble never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ctrl_q <= srpi_pkg::TX_CTRL_RST;
      rx_ctrl_q <= srpi_pkg::RX_CTRL_RST;
      g1_val_q <= srpi_pkg::G1_VAL_RST;
    end else begin
      if (wr_lane && wr_tx) tx_ctrl_q <= wdata_q;
      if (wr_lane && wr_rx) begin
        rx_ctrl_q <= wdata_q & srpi_pkg::RX_CTRL_RW_MASK;
      end
      if (wr_lane && wr_g1) g1_val_q <= wdata_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Receive parity result
  // Count of erred B3 bits
  logic [3:0] psum [0:8];
  assign psum[0] = 4'h0;
  for (genvar i = 0; i < 8; i++) begin : g_pop
    assign psum[i+1] = psum[i] + {3'h0, b3_err_mask[i]};
  end
  // Latest receive-side parity result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latest_cnt_q <= 4'h0;
      latest_err_q <= 1'b0;
    end else if (b3_done) begin
      latest_cnt_q <= psum[8];
      latest_err_q <= |b3_err_mask;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Serial overhead port
  logic [1:0] div_q;
  logic oh_clk_q, oh_en_q, start_req_q, sin_s1_q, sin_s2_q;
  logic [5:0] per_q;
  // Port clock divider; rise marks the device sampling edge
  wire oh_tick = div_q == srpi_pkg::OH_HALF_CYC;
  wire oh_rise = oh_tick && !oh_clk_q;
  wire oh_cap = oh_busy && per_q >= srpi_pkg::OH_CAP_FIRST &&
                per_q <= srpi_pkg::OH_CAP_LAST;
  wire spe_go = spe_in_valid && spe_in.spe_start;
  // Port clock toggle and pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 2'h0;
      oh_clk_q <= 1'b0;
      sin_s1_q <= 1'b0;
      sin_s2_q <= 1'b0;
    end else begin
      div_q <= oh_tick ? 2'h0 : div_q + 2'h1;
      if (oh_tick) oh_clk_q <= !oh_clk_q;
      sin_s1_q <= serial_overhead_input;
      sin_s2_q <= sin_s1_q;
    end
  end
  // Frame pulse, wait, then four bits latched on rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oh_state_q <= srpi_pkg::OH_IDLE;
      start_req_q <= 1'b0;
      oh_en_q <= 1'b0;
      per_q <= 6'h00;
      ext_shift_q <= 4'h0;
      ext_rei_q <= 4'h0;
    end else begin
      if (spe_go) start_req_q <= 1'b1;
      if (oh_rise) begin
        oh_en_q <= 1'b0;
        per_q <= per_q + 6'h01;
        if (oh_cap) ext_shift_q <= {ext_shift_q[2:0], sin_s2_q};
        if (oh_busy && per_q == srpi_pkg::OH_CAP_LAST) begin
          ext_rei_q <= {ext_shift_q[2:0], sin_s2_q};
          oh_state_q <= srpi_pkg::OH_IDLE;
        end
        if (start_req_q && !spe_go) begin
          start_req_q <= 1'b0;
          oh_state_q <= srpi_pkg::OH_RUN;
          oh_en_q <= 1'b1;
          per_q <= 6'h00;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // REI-P selection and G1 insertion
  wire [1:0] rei_sel = tx_ctrl_q[srpi_pkg::REI_SEL_LSB +: 2];
  wire style_flag = rx_ctrl_q[srpi_pkg::RPT_STYLE_BIT];
  wire [3:0] auto_val = style_flag ? {3'h0, latest_err_q} : latest_cnt_q;
  wire [3:0] soft_val = g1_val_q[srpi_pkg::G1_REI_LSB +: 4];
  wire [3:0] rei_pick = rei_sel == srpi_pkg::SRC_SOFT ? soft_val :
                        rei_sel == srpi_pkg::SRC_SERIAL ? ext_rei_q :
                        auto_val;
  wire [3:0] rei_now = spe_go ? rei_pick : frame_rei_q;
  wire [7:0] g1_byte = {rei_now, spe_in.data[3:0]};
  // Per-SPE sample and registered output byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_rei_q <= 4'h0;
      spe_out <= '0;
      spe_out_valid <= 1'b0;
    end else begin
      if (spe_go) frame_rei_q <= rei_pick;
      spe_out_valid <= spe_in_valid;
      spe_out <= spe_in;
      if (spe_in_valid && spe_in.g1) spe_out.data <= g1_byte;
    end
  end
  // Ports straight from their flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign overhead_port_clock = oh_clk_q;
  assign overhead_port_enable_out = oh_en_q;
  assign overhead_port_frame_out = oh_en_q;
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  auto_count_a: assert property (
    spe_go && rei_sel == srpi_pkg::SRC_AUTO && !style_flag
    |=> frame_rei_q == $past(latest_cnt_q) && frame_rei_q <= 4'h8)
    else $error("auto count value wrong");
  auto_flag_a: assert property (
    spe_go && rei_sel == srpi_pkg::SRC_AUTO && style_flag
    |=> frame_rei_q == {3'h0, $past(latest_err_q)})
    else $error("auto flag value wrong");
  soft_value_a: assert property (
    spe_go && rei_sel == srpi_pkg::SRC_SOFT
    |=> frame_rei_q == $past(g1_val_q[7:4]))
    else $error("software value not copied");
  serial_value_a: assert property (
    spe_go && rei_sel == srpi_pkg::SRC_SERIAL
    |=> frame_rei_q == $past(ext_rei_q))
    else $error("serial value not used");
  g1_insert_a: assert property (
    spe_in_valid && spe_in.g1 |=> spe_out_valid &&
    spe_out.data[7:4] == frame_rei_q &&
    spe_out.data[3:0] == $past(spe_in.data[3:0]))
    else $error("G1 field not inserted");
  frame_hold_a: assert property (!spe_go |=> $stable(frame_rei_q))
    else $error("value changed inside frame");
  pop_count_a: assert property (
    b3_done && b3_err_mask == 8'hFF |=> latest_cnt_q == 4'h8)
    else $error("bit count wrong");
  rx_upper_a: assert property (rx_ctrl_q[7:4] == 4'h0)
    else $error("read-only bits set");
  tx_write_a: assert property (
    wr_lane && wr_tx |=> tx_ctrl_q == $past(wdata_q))
    else $error("control write lost");
  style_pick_a: assert property (
    rei_sel == srpi_pkg::SRC_AUTO && style_flag && latest_err_q
    |-> rei_pick == 4'h1)
    else $error("report style ignored");
  pulse_len_a: assert property (
    $rose(oh_en_q) |-> oh_en_q [*8] ##1 !oh_en_q)
    else $error("frame pulse length wrong");
  auto_c: cover property (spe_go && rei_sel == srpi_pkg::SRC_AUTO);
  soft_c: cover property (spe_go && rei_sel == srpi_pkg::SRC_SOFT);
  serial_c: cover property (oh_busy && per_q == srpi_pkg::OH_CAP_LAST);
endmodule

// file: rtl/srpi_pkg.sv
package srpi_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] TX_CTRL_IDX = 16'h1983;
  localparam logic [15:0] RX_CTRL_IDX = 16'h1183;
  localparam logic [15:0] G1_VAL_IDX = 16'h199F;
  localparam logic [15:0] STATUS_IDX = 16'h1184;

  // Reset values and the receive control write mask
  localparam logic [7:0] TX_CTRL_RST = 8'h00;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] G1_VAL_RST = 8'h00;
  localparam logic [7:0] RX_CTRL_RW_MASK = 8'h0F;

  // Field positions
  localparam int unsigned REI_SEL_LSB = 5;
  localparam int unsigned RPT_STYLE_BIT = 0;
  localparam int unsigned G1_REI_LSB = 4;

  // Remote error source selector codes
  localparam logic [1:0] SRC_AUTO = 2'h0;
  localparam logic [1:0] SRC_SOFT = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;

  // Overhead port timing, in aclk cycles and port clock periods
  localparam logic [1:0] OH_HALF_CYC = 2'h3;
  localparam logic [5:0] OH_WAIT_PERIODS = 6'h1C;
  localparam logic [5:0] OH_CAP_FIRST = OH_WAIT_PERIODS + 6'h01;
  localparam logic [5:0] OH_CAP_LAST = OH_CAP_FIRST + 6'h03;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One byte of the outbound SPE stream
  typedef struct packed {
    logic [7:0] data;
    logic spe_start;
    logic g1;
  } srpi_byte_t;

  typedef enum logic {OH_IDLE, OH_RUN} srpi_oh_state_t;

endpackage

// file: test/srpi_far_end.sv
// Far end serial source that feeds remote error bits to the overhead port
module srpi_far_end (
  input wire logic oclk,
  input wire logic en,
  input wire logic fr,
  input wire logic [3:0] val,
  output logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;

  ////////////////////////////////////////////////////////////////////////
  // Watch strobes, wait out the overhead, shift four bits on falling edges
  initial begin
    sdo = 1'b0;
    forever begin
      @(negedge oclk);
      if (en === 1'b1 && fr === 1'b1) begin
        @(posedge oclk);
        repeat (28) @(posedge oclk);
        for (i = 3; i >= 0; i--) begin
          @(negedge oclk);
          sdo = val[i];
        end
        @(negedge oclk);
        sdo = ~sdo; // Hold over: line no longer shows the last bit
      end
    end
  end
endmodule

// file: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("Error at %0t: got %h expected %h", \
  $time, g, e); end end
  logic aclk;
  logic aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, b3_done = 0, spe_in_valid = 0;
  logic [15:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0, sval = 4'h9;
  logic [7:0] b3_err_mask = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, spe_out_valid;
  logic sdi, pclk, pen, pfr;
  srpi_pkg::srpi_byte_t spe_in = '0, spe_out;
  int fail_count = 0, samples_checked = 0, cyc = 0;

  ////////////////////////////////////////////////////////////////////////
  // Design and far end
  srpi_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .b3_done(b3_done), .b3_err_mask(b3_err_mask),
    .spe_in(spe_in), .spe_in_valid(spe_in_valid), .spe_out(spe_out),
    .spe_out_valid(spe_out_valid), .serial_overhead_input(sdi),
    .overhead_port_clock(pclk), .overhead_port_enable_out(pen),
    .overhead_port_frame_out(pfr));
  srpi_far_end far_u (.oclk(pclk), .en(pen), .fr(pfr), .val(sval),
    .sdo(sdi));

  // Clock and hang guard
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus and stream tasks
  function automatic logic [15:0] ad(input logic [15:0] i);
    return {i[13:0], 2'b00};
  endfunction
  task automatic wre(input logic [15:0] i, input logic [7:0] d,
                     input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 0;
    @(posedge aclk);
    awaddr <= ad(i);
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
      if (hb) bready <= 0;
    end
    `CHK(r, er)
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    wre(i, d, srpi_pkg::RESP_OKAY);
  endtask
  task automatic rc(input logic [15:0] i, input logic [7:0] e,
                    input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    hr = 0;
    @(posedge aclk);
    araddr <= ad(i);
    arvalid <= 1;
    rready <= 1;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 0;
      if (hr) rready <= 0;
    end
    `CHK(d, {24'h0, e})
    `CHK(r, er)
  endtask
  task automatic b3(input logic [7:0] m);
    @(posedge aclk);
    b3_done <= 1;
    b3_err_mask <= m;
    @(posedge aclk);
    b3_done <= 0;
  endtask
  // Start byte, filler (optional new B3 result), then the G1 byte
  task automatic frame(input logic [3:0] e, input logic chk,
                       input logic mid, input logic [7:0] mm);
    @(posedge aclk);
    spe_in <= {8'h00, 2'b10};
    spe_in_valid <= 1;
    @(posedge aclk);
    spe_in <= {8'h11, 2'b00};
    b3_done <= mid;
    b3_err_mask <= mm;
    @(posedge aclk);
    spe_in <= {8'h3C, 2'b01};
    b3_done <= 0;
    @(posedge aclk);
    spe_in_valid <= 0;
    #1;
    if (chk) `CHK({spe_out, spe_out_valid}, {e, 4'hC, 2'b01, 1'b1})
    repeat (16) @(posedge aclk); // Keep port start pulses apart
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    rc(srpi_pkg::TX_CTRL_IDX, 8'h00, srpi_pkg::RESP_OKAY);
    rc(srpi_pkg::RX_CTRL_IDX, 8'h00, srpi_pkg::RESP_OKAY);
    rc(16'h0001, 8'h00, srpi_pkg::RESP_SLVERR);
    wre(16'h0001, 8'h55, srpi_pkg::RESP_SLVERR);
    wr(srpi_pkg::TX_CTRL_IDX, 8'hFF);
    rc(srpi_pkg::TX_CTRL_IDX, 8'hFF, srpi_pkg::RESP_OKAY);
    wr(srpi_pkg::RX_CTRL_IDX, 8'hFE);
    rc(srpi_pkg::RX_CTRL_IDX, 8'h0E, srpi_pkg::RESP_OKAY);
    wr(srpi_pkg::RX_CTRL_IDX, 8'h00);
    wr(srpi_pkg::TX_CTRL_IDX, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_auto;
    logic [7:0] mk [5] = '{8'h00, 8'h01, 8'h81, 8'h7E, 8'hFF};
    logic [3:0] ek [5] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8};
    for (int k = 0; k < 5; k++) begin
      b3(mk[k]);
      frame(ek[k], 1, 0, 8'h00);
    end
    wr(srpi_pkg::RX_CTRL_IDX, 8'h01);
    frame(4'h1, 1, 0, 8'h00);
    b3(8'h24);
    frame(4'h1, 1, 0, 8'h00);
    b3(8'h00);
    frame(4'h0, 1, 0, 8'h00);
    wr(srpi_pkg::RX_CTRL_IDX, 8'h00);
    wr(srpi_pkg::TX_CTRL_IDX, 8'h60);
    b3(8'h03);
    frame(4'h2, 1, 1, 8'hFF);
    frame(4'h8, 1, 0, 8'h00);
    $display("test auto done");
  endtask
  task automatic t_soft;
    wr(srpi_pkg::TX_CTRL_IDX, 8'h20);
    wr(srpi_pkg::G1_VAL_IDX, 8'hA5);
    frame(4'hA, 1, 0, 8'h00);
    wr(srpi_pkg::G1_VAL_IDX, 8'h5A);
    frame(4'h5, 1, 1, 8'hFF);
    $display("test soft done");
  endtask
  task automatic t_serial;
    wr(srpi_pkg::TX_CTRL_IDX, 8'h40);
    repeat (320) @(posedge aclk); // Let the earlier capture finish
    frame(4'h0, 0, 0, 8'h00);
    repeat (320) @(posedge aclk);
    sval = 4'h6;
    frame(4'h9, 1, 0, 8'h00);
    repeat (320) @(posedge aclk);
    frame(4'h6, 1, 0, 8'h00);
    rc(srpi_pkg::STATUS_IDX, 8'h36, srpi_pkg::RESP_OKAY);
    $display("test serial done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_auto();
    t_soft();
    t_serial();
    complete_run();
  end
endmodule
